/* design/mv_regs.svh */
// Purpose: named constants shared by both ends of the multivibrator link
// Assumes: included by bare name from the device and partner design files
// Notes:   widths, counts and reset values only; the logic still holds bare figures such as 1
`ifndef MV_REGS_SVH
`define MV_REGS_SVH

// ****************************************************************
// widths
// ****************************************************************
`define MV_CNT_W_DEF     32'h0000_0010
`define MV_DIV_W_DEF     32'h0000_0008
`define MV_CNT_W_MIN     32'h0000_0002
`define MV_CNT_W_MAX     32'h0000_0020

// ****************************************************************
// timing counts, in clock cycles
// ****************************************************************
`define MV_MIN_HALF      32'h0000_0002
`define MV_POR_HOLD      32'h0000_0008

// ****************************************************************
// reset values of edge history and abort clear
// ****************************************************************
`define MV_RISE_PREV_RST 1'b1
`define MV_FALL_PREV_RST 1'b0
`define MV_EXT_PREV_RST  1'b1
`define MV_ABORT_RST     1'b1

`endif

/* design/mv_pkg.sv */
// Purpose: types shared by both ends of the multivibrator link
// Assumes: nothing beyond the constants header
// Notes:   state codes are written out in binary
package mv_pkg;

  // ****************************************************************
  // device states
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_ASTABLE = 2'b01,
    ST_ONESHOT = 2'b10
  } dev_state_t;

  // ****************************************************************
  // partner states
  // ****************************************************************
  typedef enum logic [1:0] {
    PS_POR   = 2'b00,
    PS_READY = 2'b01,
    PS_LONG  = 2'b10
  } ptn_state_t;

endpackage

/* design/mv_link_if.sv */
// Purpose: pin-level link between the multivibrator and its partner
// Assumes: single clock, all pins driven from flip-flops
// Notes:   no two-way pins, so no enables are needed
`timescale 1ns/1ps

interface mv_link_if;
  // ****************************************************************
  // partner to device
  // ****************************************************************
  logic free_run_enable;
  logic free_run_enable_n;
  logic rise_fire_input;
  logic fall_fire_input;
  logic pulse_extend_input;
  logic pulse_abort_clear;
  // ****************************************************************
  // device to partner
  // ****************************************************************
  logic pulse_out;
  logic pulse_out_n;
  logic double_rate_out;

  modport dev (
    input  free_run_enable,
    input  free_run_enable_n,
    input  rise_fire_input,
    input  fall_fire_input,
    input  pulse_extend_input,
    input  pulse_abort_clear,
    output pulse_out,
    output pulse_out_n,
    output double_rate_out
  );

  modport ptn (
    output free_run_enable,
    output free_run_enable_n,
    output rise_fire_input,
    output fall_fire_input,
    output pulse_extend_input,
    output pulse_abort_clear,
    input  pulse_out,
    input  pulse_out_n,
    input  double_rate_out
  );
endinterface // mv_link_if

/* design/mv_device.sv */
// Purpose: one-shot / free-running multivibrator timed by a cycle count
// Assumes: link inputs synchronous to CLK; partner clears after power-up
// Notes:   every output is one flip-flop away from its cause
`timescale 1ns/1ps
`include "mv_regs.svh"

module mv_device
  import mv_pkg::*;
#(
  parameter int CNT_W = `MV_CNT_W_DEF
) (
  // clock and reset
  input  wire logic             CLK,
  input  wire logic             SYS_RST,
  // link to partner
  mv_link_if.dev                LINK,
  // timing
  input  wire logic [CNT_W-1:0] HALF_COUNT,
  // status
  output logic                  ONESHOT_BUSY,
  output logic                  ASTABLE_RUN,
  output logic                  TRIG_IGNORED
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (CNT_W < `MV_CNT_W_MIN || CNT_W > `MV_CNT_W_MAX) begin : g_bad_w
    $error("mv_device: CNT_W out of range");
  end

  localparam logic [CNT_W-1:0] MIN_HALF = CNT_W'(`MV_MIN_HALF);
  localparam logic [CNT_W-1:0] ONE      = CNT_W'(1);

  // ****************************************************************
  // declarations
  // ****************************************************************
  dev_state_t       state_q;
  dev_state_t       state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             pulse_q;
  logic             pulse_d;
  logic             pulse_n_q;
  logic             dbl_q;
  logic             dbl_d;
  logic             rise_prev_q;
  logic             fall_prev_q;
  logic             ext_prev_q;
  logic             busy_q;
  logic             run_q;
  logic             ign_q;
  logic             ign_d;
  logic [CNT_W-1:0] eff_half;
  logic [CNT_W-1:0] dbl_split;
  logic             gate_on;
  logic             fire;
  logic             retrig;
  logic             last;
  logic             abort;

  // ****************************************************************
  // input decode
  // ****************************************************************
  // counts below the floor would leave no room for the double-rate split
  assign eff_half  = (HALF_COUNT < MIN_HALF) ? MIN_HALF : HALF_COUNT;
  assign dbl_split = eff_half >> 1;
  assign last      = (cnt_q == eff_half - ONE);

  // either polarity of gate runs the oscillator
  assign gate_on = LINK.free_run_enable | ~LINK.free_run_enable_n;

  // edges only: trigger level or duration never reaches the timer
  assign fire = (LINK.rise_fire_input & ~rise_prev_q)
              | (~LINK.fall_fire_input & fall_prev_q);
  assign retrig = LINK.pulse_extend_input & ~ext_prev_q;
  assign abort  = LINK.pulse_abort_clear;

  // ****************************************************************
  // edge history
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rise_prev_q <= `MV_RISE_PREV_RST;
      fall_prev_q <= `MV_FALL_PREV_RST;
      ext_prev_q  <= `MV_EXT_PREV_RST;
    end else begin
      rise_prev_q <= LINK.rise_fire_input;
      fall_prev_q <= LINK.fall_fire_input;
      ext_prev_q  <= LINK.pulse_extend_input;
    end
  end

  // ****************************************************************
  // timer next state
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    pulse_d = pulse_q;
    ign_d   = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        pulse_d = 1'b0;
        cnt_d   = '0;
        if (fire) begin
          state_d = ST_ONESHOT;
          pulse_d = 1'b1;
        end else if (gate_on) begin
          state_d = ST_ASTABLE;
          pulse_d = 1'b1;
        end
      end
      ST_ASTABLE: begin
        if (fire) begin
          state_d = ST_ONESHOT;
          cnt_d   = '0;
          pulse_d = 1'b1;
        end else if (!gate_on) begin
          state_d = ST_IDLE;
          cnt_d   = '0;
          pulse_d = 1'b0;
        end else if (last) begin
          cnt_d   = '0;
          pulse_d = ~pulse_q;
        end else begin
          cnt_d = cnt_q + ONE;
        end
      end
      ST_ONESHOT: begin
        if (retrig) begin
          cnt_d   = '0;
          pulse_d = 1'b1;
        end else if (last) begin
          state_d = ST_IDLE;
          cnt_d   = '0;
          pulse_d = 1'b0;
        end else begin
          cnt_d = cnt_q + ONE;
        end
        // without the extend input a new edge cannot stretch the pulse
        ign_d = fire & ~retrig;
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d   = '0;
        pulse_d = 1'b0;
      end
    endcase
    if (abort) begin
      state_d = ST_IDLE;
      cnt_d   = '0;
      pulse_d = 1'b0;
      ign_d   = 1'b0;
    end
    // high over the first part of each half-period; duty is uneven on odd
    dbl_d = (state_d != ST_IDLE) && (cnt_d < dbl_split);
  end

  // ****************************************************************
  // timer registers
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_q   <= ST_IDLE;
      cnt_q     <= '0;
      pulse_q   <= 1'b0;
      pulse_n_q <= 1'b1;
      dbl_q     <= 1'b0;
      busy_q    <= 1'b0;
      run_q     <= 1'b0;
      ign_q     <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      pulse_q   <= pulse_d;
      pulse_n_q <= ~pulse_d;
      dbl_q     <= dbl_d;
      busy_q    <= (state_d == ST_ONESHOT);
      run_q     <= (state_d == ST_ASTABLE);
      ign_q     <= ign_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign LINK.pulse_out       = pulse_q;
  assign LINK.pulse_out_n     = pulse_n_q;
  assign LINK.double_rate_out = dbl_q;
  assign ONESHOT_BUSY         = busy_q;
  assign ASTABLE_RUN          = run_q;
  assign TRIG_IGNORED         = ign_q;

endmodule // mv_device

/* design/mv_partner.sv */
// Purpose: trigger, gate and divide-by-N logic facing the multivibrator
// Assumes: device timing count set on the device side
// Notes:   holds abort clear for a while after reset
`timescale 1ns/1ps
`include "mv_regs.svh"

module mv_partner
  import mv_pkg::*;
#(
  parameter int DIV_W    = `MV_DIV_W_DEF,
  parameter int POR_HOLD = `MV_POR_HOLD
) (
  // clock and reset
  input  wire logic             CLK,
  input  wire logic             SYS_RST,
  // link to device
  mv_link_if.ptn                LINK,
  // user control
  input  wire logic             TRIG,
  input  wire logic             EDGE_FALL,
  input  wire logic             RETRIG_EN,
  input  wire logic             LONG_EN,
  input  wire logic [DIV_W-1:0] DIV_N,
  input  wire logic             GATE_EN,
  input  wire logic             GATE_USE_N,
  input  wire logic             ABORT_REQ,
  // status
  output logic                  READY,
  output logic                  LONG_BUSY
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (DIV_W < 1 || DIV_W > `MV_CNT_W_MAX || POR_HOLD < 1) begin : g_bad
    $error("mv_partner: bad parameter");
  end

  localparam logic [7:0]       HOLD  = 8'(POR_HOLD);
  localparam logic [7:0]       HONE  = 8'(1);
  localparam logic [DIV_W-1:0] DONE_ = DIV_W'(1);

  // ****************************************************************
  // declarations
  // ****************************************************************
  ptn_state_t       st_q;
  ptn_state_t       st_d;
  logic [7:0]       por_q;
  logic [7:0]       por_d;
  logic [DIV_W-1:0] rises_q;
  logic [DIV_W-1:0] rises_d;
  logic             trig_q;
  logic             pout_prev_q;
  logic             trig_rise;
  logic             pout_rise;
  logic             fre_q, fre_d, fren_q, fren_d;
  logic             rfi_q, rfi_d, ffi_q, ffi_d;
  logic             ext_q, ext_d, abort_q, abort_d;
  logic             ready_q;
  logic             long_q;

  assign trig_rise = TRIG & ~trig_q;
  assign pout_rise = LINK.pulse_out & ~pout_prev_q;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_d    = st_q;
    por_d   = por_q;
    rises_d = rises_q;
    abort_d = ABORT_REQ;
    unique case (st_q)
      PS_POR: begin
        abort_d = 1'b1;
        if (por_q == HOLD - HONE) begin
          st_d = PS_READY;
        end else begin
          por_d = por_q + HONE;
        end
      end
      PS_READY: begin
        if (LONG_EN && trig_rise) begin
          st_d    = PS_LONG;
          rises_d = '0;
        end
      end
      PS_LONG: begin
        // release after N whole periods, at the next rising output
        if (trig_rise) begin
          rises_d = '0;
        end else if (pout_rise) begin
          if (rises_q == DIV_N) begin
            st_d = PS_READY;
          end else begin
            rises_d = rises_q + DONE_;
          end
        end
      end
      default: st_d = PS_POR;
    endcase
    // long mode hands timing to the counter, so triggers stay idle
    rfi_d  = EDGE_FALL | (TRIG & ~LONG_EN);
    ffi_d  = EDGE_FALL & ~(TRIG & ~LONG_EN);
    ext_d  = RETRIG_EN & ~EDGE_FALL & TRIG & ~LONG_EN;
    fre_d  = GATE_EN & ~GATE_USE_N;
    fren_d = ~((st_d == PS_LONG) | (GATE_EN & GATE_USE_N));
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      st_q        <= PS_POR;
      por_q       <= '0;
      rises_q     <= '0;
      trig_q      <= 1'b0;
      pout_prev_q <= 1'b0;
      fre_q       <= 1'b0;
      fren_q      <= 1'b1;
      rfi_q       <= 1'b0;
      ffi_q       <= 1'b0;
      ext_q       <= 1'b0;
      abort_q     <= `MV_ABORT_RST;
      ready_q     <= 1'b0;
      long_q      <= 1'b0;
    end else begin
      st_q        <= st_d;
      por_q       <= por_d;
      rises_q     <= rises_d;
      trig_q      <= TRIG;
      pout_prev_q <= LINK.pulse_out;
      fre_q       <= fre_d;
      fren_q      <= fren_d;
      rfi_q       <= rfi_d;
      ffi_q       <= ffi_d;
      ext_q       <= ext_d;
      abort_q     <= abort_d;
      // status from flops, same edge as the state it reports
      ready_q     <= (st_d != PS_POR);
      long_q      <= (st_d == PS_LONG);
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign LINK.free_run_enable    = fre_q;
  assign LINK.free_run_enable_n  = fren_q;
  assign LINK.rise_fire_input    = rfi_q;
  assign LINK.fall_fire_input    = ffi_q;
  assign LINK.pulse_extend_input = ext_q;
  assign LINK.pulse_abort_clear  = abort_q;
  assign READY                   = ready_q;
  assign LONG_BUSY               = long_q;

endmodule // mv_partner

/* tb/mv_assertions.sv */
// Purpose: protocol checks on the multivibrator link
// Assumes: HALF_COUNT held at EFF for the whole run
// Notes:   sees only the link pins, no bind
`timescale 1ns/1ps

module mv_assertions #(
  parameter int EFF = 4
) (
  // clock and reset
  input wire logic CLK,
  input wire logic SYS_RST,
  // partner to device
  input wire logic free_run_enable,
  input wire logic free_run_enable_n,
  input wire logic rise_fire_input,
  input wire logic fall_fire_input,
  input wire logic pulse_extend_input,
  input wire logic pulse_abort_clear,
  // device to partner
  input wire logic pulse_out,
  input wire logic pulse_out_n,
  input wire logic double_rate_out
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  logic       gate;
  logic [7:0] run_q;

  assign gate = free_run_enable | ~free_run_enable_n;

  // cycles since the last change; an edge on pulse_out or either fire input restarts it
  always_ff @(posedge CLK) begin
    if (SYS_RST || !gate || pulse_abort_clear || $changed(pulse_out)
        || $changed(rise_fire_input) || $changed(fall_fire_input)) begin
      run_q <= 8'h00;
    end else begin
      run_q <= run_q + 8'h01;
    end
  end

  sequence s_fire;
    ($rose(rise_fire_input) || $fell(fall_fire_input))
      && !pulse_abort_clear && !pulse_out;
  endsequence

  // no edge, no abort, no gate: timing left to run alone
  sequence s_quiet;
    !pulse_abort_clear && !$rose(rise_fire_input) && !gate
      && !$fell(fall_fire_input) && !$rose(pulse_extend_input);
  endsequence

  sequence s_retrig;
    $rose(pulse_extend_input) && $rose(rise_fire_input) && pulse_out
      && !pulse_abort_clear;
  endsequence

  // ****************************************************************
  // checks
  // ****************************************************************
  a_outputs_complement: assert property (pulse_out_n == ~pulse_out)
    else $error("pulse_out_n is not the complement");
  a_abort_quiet: assert property (
    pulse_abort_clear |=> !pulse_out && pulse_out_n)
    else $error("pulse seen while abort clear high");
  a_abort_ends: assert property (
    pulse_out && pulse_abort_clear |=> $fell(pulse_out))
    else $error("abort did not end the pulse");
  a_fire_starts: assert property (s_fire |=> pulse_out)
    else $error("fire edge did not start a pulse");
  a_oneshot_width: assert property (
    s_fire ##1 s_quiet [*4] |-> pulse_out && $past(pulse_out, 3)
      ##1 !pulse_out)
    else $error("one-shot width wrong");
  a_retrig_holds: assert property (
    s_retrig ##1 !pulse_abort_clear [*3] |-> $past(pulse_out, 2)
      && pulse_out ##1 pulse_out)
    else $error("pulse_extend_input did not hold the pulse");
  a_astable_toggle: assert property (run_q < EFF)
    else $error("oscillator half period too long");
  a_osc_rate: assert property (
    $changed(pulse_out) && gate && !pulse_abort_clear
      |-> double_rate_out ##2 !double_rate_out)
    else $error("double rate output wrong");
endmodule // mv_assertions

/* tb/tb_oneshot_astable_multivibrator.sv */
// Purpose: end-to-end test of device and partner joined by the link
// Assumes: HALF_COUNT fixed at 4, so every high run not extended or cut short is 4 cycles
// Notes:   expected high-run lengths queued by the driver
`timescale 1ns/1ps

module tb_oneshot_astable_multivibrator;
  import mv_pkg::*;
  // ****************************************************************
  // stimulus and bookkeeping
  // ****************************************************************
  logic        clk        = 1'b0;
  logic        sys_rst    = 1'b1;
  logic        trig       = 1'b0;
  logic        edge_fall  = 1'b0;
  logic        retrig_en  = 1'b0;
  logic        gate_en    = 1'b0;
  logic        gate_use_n = 1'b0;
  logic        abort_req  = 1'b0;
  logic        ready;
  logic        long_en    = 1'b0;
  logic [7:0]  div_n      = 8'h00;
  logic        mode_os    = 1'b1;
  logic        busy;
  logic        run;
  logic        ign;
  logic        long_busy;
  int          n_ign      = 0;
  int          n_long     = 0;
  logic [15:0] half_count = 16'h0004;
  int          n_errors   = 0;
  int          cmp_count  = 0;
  int          seed       = 27924;
  int          cyc        = 0;
  int          len        = 0;
  int          d;
  int          exp_q[$];

  always #25 clk = ~clk;

  mv_link_if u_mv_link_if();

  mv_device #(.CNT_W(16)) u_mv_device (
    .CLK(clk), .SYS_RST(sys_rst), .LINK(u_mv_link_if.dev),
    .HALF_COUNT(half_count), .ONESHOT_BUSY(busy), .ASTABLE_RUN(run),
    .TRIG_IGNORED(ign));

  mv_partner #(.POR_HOLD(2)) u_mv_partner (
    .CLK(clk), .SYS_RST(sys_rst), .LINK(u_mv_link_if.ptn), .TRIG(trig),
    .EDGE_FALL(edge_fall), .RETRIG_EN(retrig_en), .LONG_EN(long_en),
    .DIV_N(div_n), .GATE_EN(gate_en), .GATE_USE_N(gate_use_n),
    .ABORT_REQ(abort_req), .READY(ready), .LONG_BUSY(long_busy));

  mv_assertions #(.EFF(4)) u_mv_assertions (
    .CLK(clk), .SYS_RST(sys_rst),
    .free_run_enable(u_mv_link_if.free_run_enable),
    .free_run_enable_n(u_mv_link_if.free_run_enable_n),
    .rise_fire_input(u_mv_link_if.rise_fire_input),
    .fall_fire_input(u_mv_link_if.fall_fire_input),
    .pulse_extend_input(u_mv_link_if.pulse_extend_input),
    .pulse_abort_clear(u_mv_link_if.pulse_abort_clear),
    .pulse_out(u_mv_link_if.pulse_out),
    .pulse_out_n(u_mv_link_if.pulse_out_n),
    .double_rate_out(u_mv_link_if.double_rate_out));

  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic fire(input int w);
    trig = 1'b1;
    tick(w);
    trig = 1'b0;
  endtask

  // ****************************************************************
  // monitor: each finished high run against the oldest note
  // ****************************************************************
  always @(posedge clk) begin
    cyc++;
    if (ign === 1'b1) n_ign++;
    if (long_busy === 1'b1) n_long++;
    if (u_mv_link_if.pulse_out === 1'b1) begin
      len++;
      check("status", 8'({busy, run}), mode_os ? 8'h02 : 8'h01);
    end else if (len != 0) begin
      if (exp_q.size() == 0) check("stray_pulse", 8'(len), 8'h00);
      else check("pulse_width", 8'(len), 8'(exp_q.pop_front()));
      len = 0;
    end
    // a hang counts against the run
    if (cyc > 1000) begin
      n_errors++;
      finish_test();
    end
  end

  initial begin
    tick(3);
    sys_rst = 1'b0;
    repeat (20) if (ready !== 1'b1) tick(1);
    repeat (4) begin
      d = 1 + ($unsigned($random(seed)) % 8);
      exp_q.push_back(4);
      fire(d);
      tick(12);
    end
    // a second edge inside the pulse is refused, width unchanged
    exp_q.push_back(4);
    fire(1);
    tick(2);
    fire(1);
    tick(12);
    $display("rising one-shot test done");
    retrig_en = 1'b1;
    tick(1);
    exp_q.push_back(10);
    repeat (3) begin
      fire(1);
      tick(2);
    end
    tick(12);
    retrig_en = 1'b0;
    $display("pulse_extend_input test done");
    d = 1 + ($unsigned($random(seed)) % 3);
    exp_q.push_back(d);
    fire(1);
    tick(d - 1);
    abort_req = 1'b1;
    tick(3);
    // mode switch under abort, so its pin edges cannot fire
    edge_fall = 1'b1;
    fire(2);
    tick(4);
    abort_req = 1'b0;
    tick(6);
    $display("abort test done");
    repeat (3) begin
      d = 1 + ($unsigned($random(seed)) % 8);
      exp_q.push_back(4);
      fire(d);
      tick(12);
    end
    $display("falling one-shot test done");
    mode_os = 1'b0;
    for (int i = 0; i < 2; i++) begin
      gate_use_n = i[0];
      tick(1);
      exp_q.push_back(4);
      exp_q.push_back(4);
      gate_en = 1'b1;
      tick(16);
      gate_en = 1'b0;
      tick(10);
    end
    $display("free-running test done");
    // falling mode kept: both trigger pins idle high, so nothing fires
    long_en = 1'b1;
    div_n   = 8'(1 + ($unsigned($random(seed)) % 3));
    tick(1);
    repeat (div_n) exp_q.push_back(4);
    // release lands one partner and one device stage into the next high
    exp_q.push_back(2);
    fire(1);
    tick(8 * div_n + 8);
    long_en = 1'b0;
    check("long_busy", 8'(n_long), 8'(8 * div_n + 2));
    $display("long pulse test done");
    check("ignored", 8'(n_ign), 8'h01);
    check("left_over", 8'(exp_q.size()), 8'h00);
    finish_test();
  end
endmodule // tb_oneshot_astable_multivibrator
